// >>> core/srp_pkg.sv
// constants shared by the reset and clock pin logic
package srp_pkg;
  localparam int unsigned SYS_CLK_KHZ       = 250000;
  localparam int unsigned WDG_MIN_MS        = 200;
  localparam int unsigned WDG_CYCLES        = WDG_MIN_MS * SYS_CLK_KHZ;
  localparam int unsigned RESET_MIN_CYCLES  = 256;
  localparam int unsigned PHY_REF_KHZ       = 25000;
  localparam int unsigned PHY_HALF_CYCLES   = SYS_CLK_KHZ / (2 * PHY_REF_KHZ);
  localparam int unsigned DDR_HALF_CYCLES   = 2;
  localparam int unsigned DIV_W             = 3;
  localparam int unsigned SYNC_STAGES       = 3;
  localparam logic [1:0]  DDR_RESERVED_IDLE = 2'h0;
endpackage

// >>> core/srp_stretch.sv
// pulse stretcher that holds its output for a fixed count of clock cycles
`timescale 1ns/100ps
module srp_stretch #(
  parameter int unsigned CYCLES = srp_pkg::WDG_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic trigger,
  output logic      active
);
  localparam int unsigned W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic         active;
    logic [W-1:0] remain;
  } srp_stretch_s;

  srp_stretch_s s_q;
  srp_stretch_s s_d;

  always_comb
  begin
    s_d = s_q;
    // a new trigger restarts the full hold time
    if (trigger)
    begin
      s_d.active = 1'b1;
      s_d.remain = W'(CYCLES - 1);
    end
    else if (s_q.remain != '0)
    begin
      s_d.remain = s_q.remain - W'(1);
    end
    else
    begin
      s_d.active = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;

  // helper: cycles the output has been high since the last trigger
  logic [W:0] held_q;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      held_q <= '0;
    end
    else if (trigger)
    begin
      held_q <= (W+1)'(1);
    end
    else if (s_q.active)
    begin
      held_q <= held_q + (W+1)'(1);
    end
    else
    begin
      held_q <= '0;
    end
  end

  property hold_min_p;
    @(posedge clock) disable iff (rst)
      (s_q.active && !s_d.active) |-> (held_q == (W+1)'(CYCLES));
  endproperty
  stretch_min_len_a: assert property (hold_min_p)
    else $error("watchdog reset output dropped before its minimum length");

  stretch_keep_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.active && s_q.remain != '0) |=> s_q.active)
    else $error("watchdog reset output fell while count remained");
endmodule

// >>> core/srp_top.sv
// chip reset input handling, watchdog reset output and clock pin outputs
`timescale 1ns/100ps
// Notes on behaviour
// - while reset input is low, the core stays in reset; clock dividers and the watchdog stretcher keep running
// - in reset every output pin is tristated, open-drain outputs float
// - on watchdog expiry the watchdog reset output is high at least 200 ms
// - two differential DDR clock pairs, true and complement, from system clock
// - a free-running 25 MHz reference clock goes out to the PHY
// - SDRAM clock enable output is deasserted for memory power-down
// - deskew loop clock goes out and returns as the deskew feedback
module srp_top #(
  parameter int unsigned WDG_CYCLES = srp_pkg::WDG_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       reset_in_n,
  input  wire logic       watchdog_expire,
  input  wire logic       sdram_power_down_req,
  input  wire logic       deskew_loop_clock_in,
  output logic            core_reset,
  output logic            pin_output_enable,
  output logic            watchdog_reset_out,
  output logic [3:0]      ddr_clock_out_p,
  output logic [3:0]      ddr_clock_out_n,
  output logic            ddr_clock_reserved_oe,
  output logic            phy_ref_clock_out,
  output logic            sdram_clock_enable_out,
  output logic            deskew_loop_clock_out,
  output logic            deskew_loop_alive
);
  localparam int unsigned SN = srp_pkg::SYNC_STAGES;
  localparam int unsigned DW = srp_pkg::DIV_W;

  typedef struct packed {
    logic [SN-1:0] pin_sync;
    logic          in_reset;
    logic          oe;
    logic [DW-1:0] ddr_cnt;
    logic          ddr_p;
    logic          ddr_n;
    logic          loop_out;
    logic [DW-1:0] ref_cnt;
    logic          ref_clk;
    logic          cke;
    logic [SN-1:0] loop_sync;
    logic          loop_lvl;
    logic          loop_alive;
  } srp_state_s;

  srp_state_s s_q;
  srp_state_s s_d;

  // next count of a divider that wraps after half-1; toggles the output at wrap
  function automatic logic [DW-1:0] div_next(input logic [DW-1:0] cnt,
                                             input int unsigned   half);
    div_next = (cnt == DW'(half - 1)) ? '0 : cnt + DW'(1);
  endfunction

  function automatic logic div_wrap(input logic [DW-1:0] cnt, input int unsigned half);
    div_wrap = (cnt == DW'(half - 1));
  endfunction

  always_comb
  begin
    s_d = s_q;
    // first stage feeds only the second stage
    s_d.pin_sync = {s_q.pin_sync[SN-2:0], reset_in_n};
    // a level change counts once stages two and three agree
    if (s_q.pin_sync[1] == s_q.pin_sync[2])
    begin
      s_d.in_reset = ~s_q.pin_sync[2];
    end
    s_d.oe = ~s_d.in_reset;

    // the divided clocks keep running through reset; only the pins are released
    s_d.ddr_cnt = div_next(s_q.ddr_cnt, srp_pkg::DDR_HALF_CYCLES);
    if (div_wrap(s_q.ddr_cnt, srp_pkg::DDR_HALF_CYCLES))
    begin
      s_d.ddr_p    = ~s_q.ddr_p;
      s_d.ddr_n    = s_q.ddr_p;
      s_d.loop_out = ~s_q.ddr_p;
    end
    s_d.ref_cnt = div_next(s_q.ref_cnt, srp_pkg::PHY_HALF_CYCLES);
    if (div_wrap(s_q.ref_cnt, srp_pkg::PHY_HALF_CYCLES))
    begin
      s_d.ref_clk = ~s_q.ref_clk;
    end

    // memory stays in power-down while held in reset
    s_d.cke = ~s_d.in_reset & ~sdram_power_down_req;

    // returned loop clock: any filtered transition proves the loop is closed
    s_d.loop_sync = {s_q.loop_sync[SN-2:0], deskew_loop_clock_in};
    if (s_q.loop_sync[1] == s_q.loop_sync[2])
    begin
      s_d.loop_lvl = s_q.loop_sync[2];
      if (s_q.loop_sync[2] != s_q.loop_lvl)
      begin
        s_d.loop_alive = 1'b1;
      end
    end
    if (s_d.in_reset)
    begin
      s_d.loop_alive = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.in_reset <= 1'b1;
      s_q.ddr_n    <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  srp_stretch #(
    .CYCLES (WDG_CYCLES)
  ) u_wdg_stretch (
    .clock   (clock),
    .rst     (rst),
    .trigger (watchdog_expire),
    .active  (watchdog_reset_out)
  );

  assign core_reset             = s_q.in_reset;
  assign pin_output_enable      = s_q.oe;
  // reserved pairs are never driven
  assign ddr_clock_out_p        = {srp_pkg::DDR_RESERVED_IDLE, {2{s_q.ddr_p}}};
  assign ddr_clock_out_n        = {srp_pkg::DDR_RESERVED_IDLE, {2{s_q.ddr_n}}};
  assign ddr_clock_reserved_oe  = 1'b0;
  assign phy_ref_clock_out      = s_q.ref_clk;
  assign sdram_clock_enable_out = s_q.cke;
  assign deskew_loop_clock_out  = s_q.loop_out;
  assign deskew_loop_alive      = s_q.loop_alive;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  core_reset_follow_a: assert property ((s_q.pin_sync[2:1] == 2'b00) |=> core_reset)
    else $error("core not held in reset while reset input low");
  pins_tristate_a: assert property (core_reset |-> !pin_output_enable)
    else $error("pins enabled during reset");
  release_synced_a: assert property (
    $fell(core_reset) |-> $past(s_q.pin_sync[2:1]) == 2'b11)
    else $error("reset released without two agreeing samples");
  ddr_pair_comp_a: assert property (ddr_clock_out_p[1:0] == ~ddr_clock_out_n[1:0])
    else $error("ddr clock pair not complementary");
  reserved_idle_a: assert property (
    ddr_clock_out_p[3:2] == 2'h0 && !ddr_clock_reserved_oe)
    else $error("reserved ddr clock pair active");
  ref_half_period_a: assert property (
    $rose(phy_ref_clock_out) |-> phy_ref_clock_out[*5] ##1 !phy_ref_clock_out)
    else $error("reference clock half period is not five cycles");
  cke_power_down_a: assert property (sdram_power_down_req |=> !sdram_clock_enable_out)
    else $error("clock enable still high during power-down request");
  loop_clock_match_a: assert property (deskew_loop_clock_out == ddr_clock_out_p[0])
    else $error("loop clock differs from ddr clock");
  wdg_start_a: assert property (watchdog_expire |=> watchdog_reset_out [*2])
    else $error("watchdog reset output not raised on expiry");

  wdg_seen_c: cover property (watchdog_expire ##1 watchdog_reset_out);
  reset_cycle_c: cover property ($rose(core_reset) ##[1:300] $fell(core_reset));
  loop_alive_c: cover property ($rose(deskew_loop_alive));
  power_down_c: cover property ($fell(sdram_clock_enable_out) && !core_reset);
endmodule

// >>> verif/srp_board_model.sv
// board reset circuit and deskew loop trace seen from the device pins
`timescale 1ns/100ps
module srp_board_model
(
  input  wire logic clock,
  input  wire logic press,
  input  wire logic loop_out,
  output logic      reset_in_n,
  output logic      loop_in
);
  int unsigned hold_q = 0;

  // the trace adds a little delay, like the routed loop
  assign #1 loop_in = loop_out;
  assign reset_in_n = (hold_q == 0);

  always @(posedge clock)
    if (press)
      hold_q <= 256;
    else if (hold_q != 0)
      hold_q <= hold_q - 1;
endmodule

// >>> verif/srp_top_test.sv
// self-checking bench for the reset input, watchdog output and clock pins
`timescale 1ns/100ps
module srp_top_test;
  localparam int unsigned WDG = 20;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       watchdog_expire = 1'b0;
  logic       sdram_power_down_req = 1'b0;
  logic       press = 1'b0;
  logic       reset_in_n;
  logic       loop_in;
  logic       loop_out;
  logic       core_reset;
  logic       pin_oe;
  logic       wdg_out;
  logic [3:0] ddr_p;
  logic [3:0] ddr_n;
  logic       rsv_oe;
  logic       phy;
  logic       cke;
  logic       alive;
  int         num_errors = 0;
  int         samples_checked = 0;

  srp_top #(.WDG_CYCLES(WDG)) srp_top_i (
    .clock(clock), .rst(rst), .reset_in_n(reset_in_n), .watchdog_expire(watchdog_expire),
    .sdram_power_down_req(sdram_power_down_req), .deskew_loop_clock_in(loop_in),
    .core_reset(core_reset), .pin_output_enable(pin_oe), .watchdog_reset_out(wdg_out),
    .ddr_clock_out_p(ddr_p), .ddr_clock_out_n(ddr_n), .ddr_clock_reserved_oe(rsv_oe),
    .phy_ref_clock_out(phy), .sdram_clock_enable_out(cke),
    .deskew_loop_clock_out(loop_out), .deskew_loop_alive(alive));

  srp_board_model srp_board_model_i (
    .clock(clock), .press(press), .loop_out(loop_out), .reset_in_n(reset_in_n),
    .loop_in(loop_in));

  initial
    forever #2 clock = ~clock;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // sample just after the edge so the edge's updates have landed
  task automatic step;
    @(posedge clock);
    #1;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic test_board_reset;
    @(posedge clock) press <= 1'b1;
    @(posedge clock) press <= 1'b0;
    repeat (5) step;
    check(8'({core_reset, pin_oe, cke}), 8'h4);
    // pin is still low here; it rises after 256 cycles, then the filter waits for two agreeing samples
    repeat (254) step;
    check(8'({core_reset, pin_oe}), 8'h2);
    step;
    check(8'({core_reset, pin_oe}), 8'h1);
    repeat (5) step;
    check(8'({core_reset, pin_oe, cke}), 8'h3);
    $display("board reset test done");
  endtask

  task automatic test_watchdog;
    int high = 0;
    @(posedge clock) watchdog_expire <= 1'b1;
    repeat (2 * WDG)
    begin
      @(posedge clock) watchdog_expire <= 1'b0;
      #1;
      if (wdg_out === 1'b1)
        high++;
    end
    check(8'(high), 8'(WDG));
    $display("watchdog test done");
  endtask

  // a second expiry half way through the pulse restarts the full hold
  task automatic test_watchdog_retrigger;
    int high = 0;
    for (int i = 0; i < 3 * WDG; i++)
    begin
      @(posedge clock) watchdog_expire <= (i == 0 || i == WDG / 2);
      #1;
      if (wdg_out === 1'b1)
        high++;
    end
    check(8'(high), 8'(WDG + WDG / 2));
    $display("watchdog retrigger test done");
  endtask

  task automatic test_power_down;
    @(posedge clock) sdram_power_down_req <= 1'b1;
    repeat (6) step;
    check(8'(cke), 8'h0);
    @(posedge clock) sdram_power_down_req <= 1'b0;
    repeat (2) step;
    check(8'(cke), 8'h1);
    $display("power down test done");
  endtask

  task automatic test_clocks;
    int   dchg = 0;
    int   pchg = 0;
    logic dp;
    logic pr;
    step;
    dp = ddr_p[0];
    pr = phy;
    repeat (100)
    begin
      step;
      if (ddr_p[0] !== dp)
        dchg++;
      if (phy !== pr)
        pchg++;
      dp = ddr_p[0];
      pr = phy;
      check(8'(ddr_n), 8'({2'h0, ~ddr_p[1:0]}));
      check(8'(loop_out), 8'(ddr_p[0]));
    end
    check(8'(dchg), 8'd50);
    check(8'(pchg), 8'd20);
    check(8'({ddr_p[3:2], rsv_oe}), 8'h0);
    check(8'(alive), 8'h1);
    $display("clock pins test done");
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    #1;
    check(8'({core_reset, pin_oe, wdg_out, cke}), 8'h8);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) step;
    check(8'({core_reset, pin_oe}), 8'h1);
    $display("power on test done");
    test_clocks();
    test_watchdog();
    test_watchdog_retrigger();
    test_power_down();
    test_board_reset();
    print_verdict();
  end

  // the tests need about 500 cycles
  initial
  begin
    #20000;
    num_errors++;
    print_verdict();
  end
endmodule
